// [pkg/eep_pkg.sv]
`default_nettype none
// ----------------------------------------
// shared constants and types
// ----------------------------------------
package eep_pkg;
	// timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int SCL_PERIOD_NS = 400;
	localparam int QTR_CYC = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
	localparam int T_WR_US = 100;
	localparam int WR_CYC = T_WR_US * 1000 / CLK_PERIOD_NS;
	// array and addressing
	localparam int ADDR_W = 15;
	localparam int MEM_WORDS = 32768;
	localparam int PAGE_W = 6;
	localparam int HI_W = ADDR_W - 8;
	localparam logic [ADDR_W-1:0] PTR_RST = 15'h0000;
	// control byte layout; device code value is arbitrary
	localparam logic [3:0] DEV_CODE = 4'h5;
	localparam int CODE_LSB = 4;
	localparam int CS_LSB = 1;
	localparam int RW_POS = 0;
	// bit counting
	localparam logic [3:0] BITS_BYTE = 4'h8;
	localparam logic [3:0] ACK_END = 4'h9;
	// idle level of synchronised pins: scl, sda high, straps low
	localparam logic [4:0] SYNC_IDLE = 5'h18;
	// read buffer
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 16;
	// host commands
	typedef enum logic [1:0] {
		EEP_OP_WRITE = 2'h0,
		EEP_OP_RAND = 2'h1,
		EEP_OP_CUR = 2'h2,
		EEP_OP_POLL = 2'h3
	} eep_op_t;
	// device states
	typedef enum logic [2:0] {
		D_IDLE = 3'h0,
		D_CTRL = 3'h1,
		D_AHI = 3'h2,
		D_ALO = 3'h3,
		D_WDATA = 3'h4,
		D_RDATA = 3'h5
	} eep_dst_t;
	// host states
	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_START = 3'h1,
		H_TX = 3'h2,
		H_RX = 3'h3,
		H_STOP = 3'h4
	} eep_hst_t;
	// host byte stage
	typedef enum logic [1:0] {
		S_CTRL = 2'h0,
		S_AHI = 2'h1,
		S_ALO = 2'h2,
		S_DATA = 2'h3
	} eep_stg_t;
endpackage : eep_pkg
`default_nettype wire

// [pkg/eep_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// two-wire link between host and device
// ----------------------------------------
interface eep_link_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;
	// open-drain data line: released ends read as pulled up
	assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
	modport host (output scl, host_sda_o, host_sda_oe, input sda);
	modport dev (input scl, sda, output dev_sda_o, dev_sda_oe);
endinterface : eep_link_if
`default_nettype wire

// [logic/eep_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// read-data fifo with registered output
// ----------------------------------------
module eep_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// fill side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL = (AW + 1)'(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0] cnt;
	logic push;
	logic load;

	// load the output stage whenever storage holds a byte and the stage is empty or being taken
	assign in_ready = cnt != FULL;
	assign push = in_valid && in_ready;
	assign load = (cnt != '0) && (!out_valid || out_ready);

	// storage, no reset needed
	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem[wp] <= in_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else if (ce) begin
			if (push) begin
				wp <= wp + 1'b1;
			end
			if (load) begin
				rp <= rp + 1'b1;
			end
			if (push && !load) begin
				cnt <= cnt + 1'b1;
			end else if (load && !push) begin
				cnt <= cnt - 1'b1;
			end
		end
	end

	// output stage keeps data steady until taken
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_data <= '0;
		end else if (ce) begin
			if (load) begin
				out_valid <= 1'b1;
				out_data <= mem[rp];
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
		end
	end
endmodule : eep_fifo
`default_nettype wire

// [logic/eep_dev.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Overview of operation
// - no acknowledge at all during write cycle
// - stop after write starts timed cycle
// - host polls with start and write control
// - host repeats poll until acknowledged
// - acknowledge poll once write cycle ends
// - read/write bit one selects read
// - pointer holds last accessed plus one
// - acknowledge read control, send pointed byte
// - host nack then stop ends read
// - address loads pointer; repeated start abandons write
// - read control after restart sends byte
// - after random read pointer is next
// - host ack requests next sequential byte
// - host ends sequential read nack, stop
// - pointer increments after each byte
// - pointer wraps from top to zero
// - respond only to own code and straps
// - address high byte first, fifteen bits
// - release data line after host nack
// ----------------------------------------
module eep_dev #(
	parameter int WR_CYCLES = eep_pkg::WR_CYC
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// chip-select straps
	input wire logic chip_select_pin_high,
	input wire logic chip_select_pin_mid,
	input wire logic chip_select_pin_low,
	// status
	output logic write_busy,
	// two-wire link
	eep_link_if.dev lnk
);
	import eep_pkg::*;

	// ----------------------------------------
	// pin sampling
	// ----------------------------------------
	logic [4:0] pin_in;
	logic [4:0] sync_m;
	logic [4:0] sync_s;
	logic scl_s;
	logic sda_s;
	logic [2:0] cs_s;
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	assign pin_in = {lnk.scl, lnk.sda, chip_select_pin_high, chip_select_pin_mid,
		chip_select_pin_low};

	// two stages before any logic; the link clock is just another pin here
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync_m <= SYNC_IDLE;
			sync_s <= SYNC_IDLE;
		end else if (ce) begin
			sync_m <= pin_in;
			sync_s <= sync_m;
		end
	end

	assign scl_s = sync_s[4];
	assign sda_s = sync_s[3];
	assign cs_s = sync_s[2:0];

	// previous levels for edge finding
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (ce) begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	// start and stop are data edges while the clock stays high
	assign scl_rise = scl_s && !scl_q;
	assign scl_fall = !scl_s && scl_q;
	assign start_seen = scl_s && scl_q && sda_q && !sda_s;
	assign stop_seen = scl_s && scl_q && !sda_q && sda_s;

	// ----------------------------------------
	// byte engine state
	// ----------------------------------------
	eep_dst_t st;
	eep_dst_t nxt;
	logic [3:0] cnt;
	logic [7:0] sh;
	logic ack_slot;
	logic sda_oe;
	logic wr_cmd;
	logic host_ack;
	logic [ADDR_W-1:0] ptr;
	logic [15:0] tmr;
	logic [7:0] mem [MEM_WORDS];
	logic [7:0] rd_byte;
	logic byte_end;
	logic ctrl_match;
	logic mem_we;

	// open-drain: only ever pull low
	assign lnk.dev_sda_o = 1'b0;
	assign lnk.dev_sda_oe = sda_oe;

	assign rd_byte = mem[ptr];
	assign byte_end = scl_fall && !ack_slot && (cnt == BITS_BYTE);
	// own code, strap levels, and never while the cell array is busy
	assign ctrl_match = (sh[7:CODE_LSB] == DEV_CODE) && (sh[CODE_LSB-1:CS_LSB] == cs_s)
		&& !write_busy;
	assign mem_we = ce && (st == D_WDATA) && byte_end;

	// ----------------------------------------
	// array
	// ----------------------------------------
	// bytes land in the array as they arrive; the timer only models busy time
	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem[ptr] <= sh;
		end
	end

	// ----------------------------------------
	// internally timed write cycle
	// ----------------------------------------
	// a stop ending a write with data starts the busy window
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			write_busy <= 1'b0;
			tmr <= '0;
		end else if (ce) begin
			if (stop_seen && wr_cmd) begin
				write_busy <= 1'b1;
				tmr <= 16'(WR_CYCLES - 1);
			end else if (write_busy) begin
				if (tmr == '0) begin
					write_busy <= 1'b0;
				end else begin
					tmr <= tmr - 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// protocol engine
	// ----------------------------------------
	// bits shift in on rising clock, the data line only changes after a fall
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= D_IDLE;
			nxt <= D_IDLE;
			cnt <= '0;
			sh <= '0;
			ack_slot <= 1'b0;
			sda_oe <= 1'b0;
			wr_cmd <= 1'b0;
			host_ack <= 1'b0;
			ptr <= PTR_RST;
		end else if (ce) begin
			if (start_seen) begin
				// a restart drops any pending write but keeps the pointer
				st <= D_CTRL;
				cnt <= '0;
				ack_slot <= 1'b0;
				sda_oe <= 1'b0;
				wr_cmd <= 1'b0;
			end else if (stop_seen) begin
				st <= D_IDLE;
				sda_oe <= 1'b0;
				wr_cmd <= 1'b0;
			end else if (st == D_RDATA) begin
				if (scl_rise) begin
					if (cnt == BITS_BYTE) begin
						host_ack <= !sda_s;
					end
					cnt <= cnt + 1'b1;
				end else if (scl_fall) begin
					if (cnt == ACK_END) begin
						if (host_ack) begin
							// next byte; top address rolls over to zero
							sh <= rd_byte;
							sda_oe <= !rd_byte[7];
							ptr <= ptr + 1'b1;
							cnt <= '0;
						end else begin
							// let go so the host can place its stop
							sda_oe <= 1'b0;
							st <= D_IDLE;
						end
					end else if (cnt == BITS_BYTE) begin
						sda_oe <= 1'b0;
					end else if (cnt != '0) begin
						sh <= {sh[6:0], 1'b0};
						sda_oe <= !sh[6];
					end
				end
			end else if (st != D_IDLE) begin
				if (scl_rise && !ack_slot && (cnt != BITS_BYTE)) begin
					sh <= {sh[6:0], sda_s};
					cnt <= cnt + 1'b1;
				end else if (byte_end) begin
					ack_slot <= 1'b1;
					case (st)
						D_CTRL: begin
							if (ctrl_match) begin
								sda_oe <= 1'b1;
								// read flag picks the direction
								nxt <= sh[RW_POS] ? D_RDATA : D_AHI;
							end else begin
								st <= D_IDLE;
							end
						end
						D_AHI: begin
							sda_oe <= 1'b1;
							ptr[ADDR_W-1:8] <= sh[HI_W-1:0];
							nxt <= D_ALO;
						end
						D_ALO: begin
							sda_oe <= 1'b1;
							ptr[7:0] <= sh;
							nxt <= D_WDATA;
						end
						D_WDATA: begin
							// writes wrap within the page
							sda_oe <= 1'b1;
							ptr[PAGE_W-1:0] <= ptr[PAGE_W-1:0] + 1'b1;
							wr_cmd <= 1'b1;
							nxt <= D_WDATA;
						end
						default: begin
							st <= D_IDLE;
						end
					endcase
				end else if (scl_fall && ack_slot) begin
					ack_slot <= 1'b0;
					cnt <= '0;
					st <= nxt;
					if (nxt == D_RDATA) begin
						// pointer moves past the byte as it is sent
						sh <= rd_byte;
						sda_oe <= !rd_byte[7];
						ptr <= ptr + 1'b1;
					end else begin
						sda_oe <= 1'b0;
					end
				end
			end
		end
	end
endmodule : eep_dev
`default_nettype wire

// [logic/eep_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// two-wire host controller
// ----------------------------------------
module eep_host (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// command
	input wire logic cmd_valid,
	input wire eep_pkg::eep_op_t cmd_op,
	input wire logic [2:0] cmd_cs,
	input wire logic [eep_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	input wire logic [7:0] cmd_len,
	output logic cmd_ready,
	// read data
	output logic rd_valid,
	output logic [7:0] rd_data,
	input wire logic rd_ready,
	// completion
	output logic done,
	output logic err,
	// two-wire link
	eep_link_if.host lnk
);
	import eep_pkg::*;

	eep_hst_t st;
	eep_stg_t stage;
	eep_op_t op;
	logic [1:0] ph;
	logic [7:0] qcnt;
	logic [3:0] bcnt;
	logic [7:0] sh;
	logic [7:0] left;
	logic [2:0] cs;
	logic [ADDR_W-1:0] addr;
	logic [7:0] wdata;
	logic rd_phase;
	logic ackd;
	logic scl;
	logic sda_oe;
	logic sda_m;
	logic sda_s;
	logic tick;
	logic hold;
	logic adv;
	logic more;
	logic drive_low;
	logic f_ready;
	logic f_push;

	assign lnk.scl = scl;
	assign lnk.host_sda_o = 1'b0;
	assign lnk.host_sda_oe = sda_oe;

	// data line passes two stages before use
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sda_m <= 1'b1;
			sda_s <= 1'b1;
		end else if (ce) begin
			sda_m <= lnk.sda;
			sda_s <= sda_m;
		end
	end

	// quarter-bit divider; link clock is made here
	assign tick = qcnt == QTR_LAST;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			qcnt <= '0;
		end else if (ce) begin
			qcnt <= (tick || st == H_IDLE) ? '0 : qcnt + 1'b1;
		end
	end

	// a full fifo stretches the clock low before the ack bit
	assign more = left > 8'h01;
	assign hold = (st == H_RX) && (bcnt == BITS_BYTE) && (ph == 2'h0) && !f_ready;
	assign adv = tick && !hold;
	assign f_push = adv && (st == H_RX) && (bcnt == BITS_BYTE) && (ph == 2'h0);
	assign drive_low = (st == H_TX) ? (bcnt != BITS_BYTE && !sh[7])
		: (bcnt == BITS_BYTE && more);

	eep_fifo #(
		.W(FIFO_W),
		.D(FIFO_D)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.in_valid(f_push),
		.in_data(sh),
		.in_ready(f_ready),
		.out_valid(rd_valid),
		.out_data(rd_data),
		.out_ready(rd_ready)
	);

	// sequencer: each bit is four quarters, actions at the end of each
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= H_IDLE;
			stage <= S_CTRL;
			op <= EEP_OP_WRITE;
			ph <= '0;
			bcnt <= '0;
			sh <= '0;
			left <= '0;
			cs <= '0;
			addr <= '0;
			wdata <= '0;
			rd_phase <= 1'b0;
			ackd <= 1'b0;
			scl <= 1'b1;
			sda_oe <= 1'b0;
			cmd_ready <= 1'b1;
			done <= 1'b0;
			err <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (st == H_IDLE) begin
				if (cmd_valid && cmd_ready) begin
					op <= cmd_op;
					cs <= cmd_cs;
					addr <= cmd_addr;
					wdata <= cmd_data;
					left <= (cmd_len == '0) ? 8'h01 : cmd_len;
					rd_phase <= cmd_op == EEP_OP_CUR;
					cmd_ready <= 1'b0;
					err <= 1'b0;
					ph <= '0;
					st <= H_START;
				end
			end else if (adv) begin
				ph <= ph + 1'b1;
				case (st)
					H_START: begin
						case (ph)
							2'h0: sda_oe <= 1'b0;
							2'h1: scl <= 1'b1;
							2'h2: sda_oe <= 1'b1;
							default: begin
								scl <= 1'b0;
								bcnt <= '0;
								stage <= S_CTRL;
								sh <= {DEV_CODE, cs, rd_phase};
								st <= H_TX;
							end
						endcase
					end
					H_STOP: begin
						case (ph)
							2'h0: sda_oe <= 1'b1;
							2'h1: scl <= 1'b1;
							2'h2: sda_oe <= 1'b0;
							default: begin
								st <= H_IDLE;
								done <= 1'b1;
								cmd_ready <= 1'b1;
							end
						endcase
					end
					default: begin
						case (ph)
							2'h0: sda_oe <= drive_low;
							2'h1: scl <= 1'b1;
							2'h2: begin
								if (bcnt == BITS_BYTE) begin
									ackd <= !sda_s;
								end else if (st == H_RX) begin
									sh <= {sh[6:0], sda_s};
								end
							end
							default: begin
								scl <= 1'b0;
								if (bcnt != BITS_BYTE) begin
									bcnt <= bcnt + 1'b1;
									if (st == H_TX) begin
										sh <= {sh[6:0], 1'b0};
									end
								end else begin
									bcnt <= '0;
									if (st == H_RX) begin
										left <= left - 1'b1;
										st <= more ? H_RX : H_STOP;
									end else if (!ackd) begin
										// busy device: poll again at once
										if (op == EEP_OP_POLL && stage == S_CTRL) begin
											st <= H_START;
										end else begin
											err <= 1'b1;
											st <= H_STOP;
										end
									end else begin
										case (stage)
											S_CTRL: begin
												if (op == EEP_OP_POLL) begin
													st <= H_STOP;
												end else if (rd_phase) begin
													st <= H_RX;
												end else begin
													stage <= S_AHI;
													sh <= {1'b0, addr[ADDR_W-1:8]};
												end
											end
											S_AHI: begin
												stage <= S_ALO;
												sh <= addr[7:0];
											end
											S_ALO: begin
												if (op == EEP_OP_WRITE) begin
													stage <= S_DATA;
													sh <= wdata;
												end else begin
													rd_phase <= 1'b1;
													st <= H_START;
												end
											end
											default: st <= H_STOP;
										endcase
									end
								end
							end
						endcase
					end
				endcase
			end
		end
	end
endmodule : eep_host
`default_nettype wire

// [sim/eep_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// link watcher for the host and device pair
// ----------------------------------------
module eep_checker #(
	parameter int WR_CYCLES = 200
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// two-wire link
	input wire logic scl,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic sda,
	// device status
	input wire logic write_busy
);
	logic [15:0] busy_cnt;
	logic [7:0] high_cnt;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// length of the timed cycle so far, cleared while idle
	always_ff @(posedge clk) begin
		if (!rst_n || !write_busy) begin
			busy_cnt <= 16'h0000;
		end else begin
			busy_cnt <= busy_cnt + 16'h0001;
		end
	end
	// cycles of clock high in a row; a bit keeps it high for six only
	always_ff @(posedge clk) begin
		if (!rst_n || !scl) begin
			high_cnt <= 8'h00;
		end else if (high_cnt != 8'hff) begin
			high_cnt <= high_cnt + 8'h01;
		end
	end
	busy_quiet_a: assert property (write_busy |-> !dev_sda_oe)
		else $error("device drives data during write cycle");
	busy_start_a: assert property ($rose(write_busy) |-> scl && sda)
		else $error("write cycle began outside a stop");
	// the timer holds busy for exactly the configured count of cycles
	busy_len_a: assert property ($fell(write_busy) |-> busy_cnt == WR_CYCLES)
		else $error("write cycle length wrong");
	busy_max_a: assert property (busy_cnt <= WR_CYCLES)
		else $error("write cycle overran");
	dev_hold_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
		else $error("device changed data while clock high");
	dev_launch_a: assert property ($rose(dev_sda_oe) |-> !scl && !$past(scl, 2))
		else $error("device launched data too soon after clock fall");
	idle_release_a: assert property (high_cnt > 8'h07 |-> !dev_sda_oe)
		else $error("device holds data line on idle link");
	dev_open_a: assert property (dev_sda_oe |-> dev_sda_o == 1'b0)
		else $error("device drives data high");
	host_open_a: assert property (host_sda_oe |-> host_sda_o == 1'b0)
		else $error("host drives data high");
	cover property ($rose(write_busy));
	cover property ($fell(write_busy));
	cover property ($rose(dev_sda_oe) && !host_sda_oe);
endmodule : eep_checker
`default_nettype wire

// [sim/serial_eeprom_read_and_ack_polling_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bench: host and device back to back
// ----------------------------------------
module serial_eeprom_read_and_ack_polling_tb;
	import eep_pkg::*;
	localparam int WR_N = 200;
	localparam int LIM = 20000;
	logic clk;
	logic rst_n;
	logic cmd_valid;
	eep_op_t cmd_op;
	logic [2:0] cmd_cs;
	logic [ADDR_W-1:0] cmd_addr;
	logic [7:0] cmd_data;
	logic [7:0] cmd_len;
	logic cmd_ready;
	logic rd_valid;
	logic [7:0] rd_data;
	logic rd_ready;
	logic done;
	logic err;
	logic write_busy;
	logic [2:0] strap;
	logic [31:0] seed;
	logic [14:0] base;
	logic [7:0] mem [logic [14:0]];
	logic [7:0] got [$];
	int bad_count;
	int cmp_count;
	eep_link_if lnk();
	eep_host i_eep_host(.clk(clk), .rst_n(rst_n), .ce(1'b1), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_cs(cmd_cs), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.cmd_len(cmd_len), .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.rd_ready(rd_ready), .done(done), .err(err), .lnk(lnk));
	eep_dev #(.WR_CYCLES(WR_N)) i_eep_dev(.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.chip_select_pin_high(strap[2]), .chip_select_pin_mid(strap[1]),
		.chip_select_pin_low(strap[0]), .write_busy(write_busy), .lnk(lnk));
	eep_checker #(.WR_CYCLES(WR_N)) i_eep_checker(.clk(clk), .rst_n(rst_n), .scl(lnk.scl),
		.host_sda_o(lnk.host_sda_o), .host_sda_oe(lnk.host_sda_oe), .dev_sda_o(lnk.dev_sda_o),
		.dev_sda_oe(lnk.dev_sda_oe), .sda(lnk.sda), .write_busy(write_busy));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	function automatic logic [7:0] exp_at(input logic [14:0] a, input int i);
		return mem[a + 15'(i)];
	endfunction : exp_at
	task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp8
	task automatic cmp1(input logic g, input logic e);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp1
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim
	// one command; reader stalls for hold cycles, so the host must stretch the clock
	task automatic run_cmd(input eep_op_t op, input logic [2:0] cs, input logic [14:0] a,
		input logic [7:0] d, input logic [7:0] n, input int hold);
		int k;
		k = 0;
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_cs = cs;
		cmd_addr = a;
		cmd_data = d;
		cmd_len = n;
		rd_ready = (hold == 0);
		got.delete();
		@(negedge clk);
		cmd_valid = 1'b0;
		while (done !== 1'b1 && k < LIM) begin
			if (k == hold - 1) begin
				cmp1(rd_valid, 1'b1);
				// a full read buffer must hold the link clock low
				cmp1(lnk.scl, 1'b0);
			end
			if (k == hold) begin
				rd_ready = 1'b1;
			end
			@(negedge clk);
			k++;
		end
		cmp1(done, 1'b1);
		cmp1(cmd_ready, 1'b1);
		rd_ready = 1'b1;
	endtask : run_cmd
	task automatic chk_read(input logic [14:0] a, input int n);
		cmp1(err, 1'b0);
		cmp8(8'(got.size()), 8'(n));
		for (int i = 0; i < n && i < got.size(); i++) begin
			cmp8(got[i], exp_at(a, i));
		end
	endtask : chk_read
	// write one byte, optionally probe the busy window, then poll
	task automatic wr(input logic [14:0] a, input logic [7:0] d, input logic probe);
		run_cmd(EEP_OP_WRITE, strap, a, d, 8'h00, 0);
		mem[a] = d;
		cmp1(err, 1'b0);
		repeat (4) @(negedge clk);
		cmp1(write_busy, 1'b1);
		if (probe) begin
			run_cmd(EEP_OP_RAND, strap, a, 8'h00, 8'h01, 0);
			cmp1(err, 1'b1);
		end
		run_cmd(EEP_OP_POLL, strap, a, 8'h00, 8'h00, 0);
		cmp1(err, 1'b0);
		cmp1(write_busy, 1'b0);
	endtask : wr
	// ----------------------------------------
	// clock, capture, watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// collect every byte the reader accepts
	always @(posedge clk) begin
		if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
			got.push_back(rd_data);
		end
	end
	// the whole sequence needs about 23k cycles
	initial begin
		repeat (100000) @(posedge clk);
		bad_count++;
		end_sim();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = EEP_OP_WRITE;
		cmd_cs = 3'h0;
		cmd_addr = 15'h0000;
		cmd_data = 8'h00;
		cmd_len = 8'h00;
		rd_ready = 1'b1;
		bad_count = 0;
		cmp_count = 0;
		seed = 32'h0001_6250; // 90704
		strap = seed[6:4];
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		seed = lfsr_next(seed);
		base = {1'b0, seed[13:0]};
		wr(base, seed[23:16], 1'b1);
		for (int i = 1; i < 22; i++) begin
			seed = lfsr_next(seed);
			wr(base + 15'(i), seed[7:0], 1'b0);
		end
		run_cmd(EEP_OP_RAND, strap, base + 15'h0005, 8'h00, 8'h01, 0);
		chk_read(base + 15'h0005, 1);
		run_cmd(EEP_OP_CUR, strap, 15'h0000, 8'h00, 8'h01, 0);
		chk_read(base + 15'h0006, 1);
		// reader stalls long enough to fill the fifo
		run_cmd(EEP_OP_RAND, strap, base, 8'h00, 8'h15, 2500);
		chk_read(base, 21);
		run_cmd(EEP_OP_CUR, strap, 15'h0000, 8'h00, 8'h01, 0);
		chk_read(base + 15'h0015, 1);
		wr(15'h7fff, seed[15:8], 1'b0);
		wr(15'h0000, seed[23:16], 1'b0);
		wr(15'h0001, seed[31:24], 1'b0);
		run_cmd(EEP_OP_RAND, strap, 15'h7fff, 8'h00, 8'h02, 0);
		chk_read(15'h7fff, 2);
		run_cmd(EEP_OP_CUR, strap, 15'h0000, 8'h00, 8'h01, 0);
		chk_read(15'h0001, 1);
		// one wrong strap bit at a time
		for (int i = 0; i < 3; i++) begin
			run_cmd(EEP_OP_CUR, strap ^ (3'h1 << i), 15'h0000, 8'h00, 8'h01, 0);
			cmp1(err, 1'b1);
		end
		end_sim();
	end
endmodule : serial_eeprom_read_and_ack_polling_tb
`default_nettype wire
